//--- hdl/ics_regs.svh
`ifndef ICS_REGS_SVH
`define ICS_REGS_SVH
// Register indices; the byte address on the bus is four times the index.
`define ICS_IDX_EDGE_SEL 10'h0e6
`define ICS_IDX_IEN_HIGH 10'h0e8
`define ICS_IDX_IEN_LOW 10'h0e9
`define ICS_IDX_PEND_HIGH 10'h0ea
`define ICS_IDX_PEND_LOW 10'h0eb
`define ICS_IDX_STATUS 10'h0ec
// Reset values.
`define ICS_RST_BYTE 8'h00
`define ICS_RST_SRC 12'h000
// Status word bit positions.
`define ICS_PSW_I_BIT 2
`define ICS_PSW_B_BIT 4
// Acceptance sequence timing in oscillator periods.
`define ICS_ACC_CYCLES 4'h8
`define ICS_CNT_PUSH_FIRST 4'h0
`define ICS_CNT_PUSH_LAST 4'h2
`define ICS_CNT_VEC_LOAD 4'h6
`define ICS_CNT_START 4'h7
`define ICS_MIN_RESPONSE 12
// Lowest-priority vector; each higher source sits one word above.
`define ICS_VEC_LOWEST 16'hffe4
`endif

//--- hdl/ics_pkg.sv
package ics_pkg;
    typedef enum logic [1:0] {
        ICS_IDLE = 2'b01,
        ICS_ACCEPT = 2'b10
    } ics_seq_state_type;
    typedef enum logic [1:0] {
        ICS_SRC_MASKABLE = 2'b00,
        ICS_SRC_NMI = 2'b01,
        ICS_SRC_BREAK = 2'b10
    } ics_src_kind_type;
endpackage

//--- hdl/ics_edge_det.sv
`timescale 1ns/1ps
module ics_edge_det (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic pin,
    input wire logic [1:0] mode,
    output logic edge_pulse
);
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic agree;

    // Three-stage synchroniser for the asynchronous pin.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    assign agree = (s2 == s3);

    // The accepted level moves only once the last two stages agree.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level <= 1'b0;
            edge_pulse <= 1'b0;
        end else begin
            if (agree) begin
                level <= s3;
            end
            edge_pulse <= agree && (s3 != level) && ((s3 && mode[1]) || (!s3 && mode[0]));
        end
    end
endmodule

//--- hdl/ics_prio_enc.sv
`timescale 1ns/1ps
module ics_prio_enc #(
    parameter int N = 12,
    parameter int W = 4
) (
    input wire logic [N-1:0] req,
    output logic found,
    output logic [W-1:0] idx
);
    // The highest set bit wins; a higher bit is a higher priority.
    always_comb begin
        found = 1'b0;
        idx = '0;
        for (int i = 0; i < N; i++) begin
            if (req[i]) begin
                found = 1'b1;
                idx = W'(i);
            end
        end
    end
endmodule

//--- hdl/ics_sequencer.sv
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`include "ics_regs.svh"
// Notes on behaviour
// RULE_01: Request stays pending until accepted or cleared.
// RULE_02: Acceptance takes eight oscillator periods.
// RULE_03: Maskable acceptance clears the global mask flag.
// RULE_04: Non-maskable acceptance blocks all later interrupts.
// RULE_05: Acceptance clears the accepted source's pending flag.
// RULE_06: Push return address and status, three pushes.
// RULE_07: Fetch vector, load program counter, start routine.
// RULE_08: Return instruction restores status, ends service.
// RULE_09: Mask flag zero blocks every maskable request.
// RULE_10: Enable instruction sets mask flag; enables select.
// RULE_11: Only program counter and status are saved.
// RULE_12: Break instruction is the lowest priority source.
// RULE_13: Break shares table call zero vector, sets flag.
// RULE_14: Higher priority request wins simultaneous arrival.
// RULE_15: Hardware polling picks among simultaneous requests.
// RULE_16: Four pins edge triggered, selectable edge modes.
// RULE_17: Edges latched each cycle, polled the next.
// RULE_18: At least twelve cycles from edge to routine.
// RULE_19: Disabled source is never accepted.
// RULE_20: Software reads and writes pending flags directly.
// RULE_21: Hardware set beats simultaneous clear.
module ics_sequencer #(
    parameter logic [15:0] BRK_VECTOR = 16'hffde,
    parameter logic [15:0] NMI_VECTOR = 16'hfffc
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ext_irq_pin_a,
    input wire logic ext_irq_pin_b,
    input wire logic ext_irq_pin_c,
    input wire logic ext_irq_pin_d,
    input wire logic [7:0] periph_irq_set,
    input wire logic nmi_req,
    input wire logic instr_done,
    input wire logic enable_irqs_instr,
    input wire logic software_break_instr,
    input wire logic return_from_service_instr,
    input wire logic [7:0] restore_psw,
    input wire logic [7:0] psw_in,
    input wire logic [15:0] ret_pc,
    output logic irq_i_flag,
    output logic psw_b_flag,
    output logic seq_busy,
    output logic stack_push,
    output logic [7:0] stack_data,
    output logic [15:0] vector_addr,
    output logic vector_load,
    output logic service_start
);
    import ics_pkg::*;

    ics_seq_state_type state;
    ics_src_kind_type kind;
    logic [7:0] ext_int_edge_select;
    logic [7:0] irq_enable_high;
    logic [7:0] irq_enable_low;
    logic [11:0] pend;
    logic [11:0] enable_all;
    logic [11:0] hw_set;
    logic [11:0] acc_clr;
    logic [11:0] next_pend;
    logic [3:0] ext_edge;
    logic [3:0] cnt;
    logic [3:0] win_idx;
    logic [3:0] acc_idx;
    logic win_found;
    logic brk_pend;
    logic nmi_pend;
    logic nmi_block;
    logic take_nmi;
    logic take_mask;
    logic take_brk;
    logic accept;
    logic wr_valid;
    logic [9:0] wr_idx;
    logic [9:0] rd_idx;
    logic [31:0] next_rdata;
    logic [7:0] saved_psw;
    logic [15:0] saved_pc;
    logic [15:0] next_vector;

    // One edge detector per external pin, two mode bits each.
    ics_edge_det u_edge_a (.hclk(hclk), .hresetn(hresetn), .pin(ext_irq_pin_a),
        .mode(ext_int_edge_select[1:0]), .edge_pulse(ext_edge[0])); // RULE_16
    ics_edge_det u_edge_b (.hclk(hclk), .hresetn(hresetn), .pin(ext_irq_pin_b),
        .mode(ext_int_edge_select[3:2]), .edge_pulse(ext_edge[1]));
    ics_edge_det u_edge_c (.hclk(hclk), .hresetn(hresetn), .pin(ext_irq_pin_c),
        .mode(ext_int_edge_select[5:4]), .edge_pulse(ext_edge[2]));
    ics_edge_det u_edge_d (.hclk(hclk), .hresetn(hresetn), .pin(ext_irq_pin_d),
        .mode(ext_int_edge_select[7:6]), .edge_pulse(ext_edge[3]));

    // Sources ordered by priority, highest at bit 11.
    assign hw_set = {ext_edge[0], ext_edge[1], periph_irq_set[7:6], ext_edge[2], ext_edge[3],
        periph_irq_set[5:0]};
    assign enable_all = {irq_enable_high, irq_enable_low[7:4]};

    // The poll looks only at latched flags gated by their enables.
    ics_prio_enc #(.N(12), .W(4)) u_prio (
        .req(pend & enable_all), // RULE_17 RULE_19
        .found(win_found),
        .idx(win_idx)
    ); // RULE_14 RULE_15

    // Candidate selection at an instruction boundary.
    assign take_nmi = (state == ICS_IDLE) && instr_done && nmi_pend && !nmi_block; // RULE_04
    assign take_mask = (state == ICS_IDLE) && instr_done && !nmi_pend && !nmi_block
        && irq_i_flag && win_found; // RULE_09 RULE_10
    assign take_brk = (state == ICS_IDLE) && instr_done && !nmi_pend && !nmi_block
        && brk_pend && !(irq_i_flag && win_found); // RULE_12
    assign accept = take_nmi || take_mask || take_brk;
    assign acc_clr = take_mask ? (12'h001 << win_idx) : `ICS_RST_SRC; // RULE_05

    // Pending flags: software write, acceptance clear, hardware set last so it wins.
    always_comb begin
        next_pend = pend;
        if (wr_valid && wr_idx == `ICS_IDX_PEND_HIGH) begin
            next_pend[11:4] = hwdata[7:0]; // RULE_20
        end else if (wr_valid && wr_idx == `ICS_IDX_PEND_LOW) begin
            next_pend[3:0] = hwdata[7:4];
        end
        next_pend = (next_pend & ~acc_clr) | hw_set; // RULE_01 RULE_21
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend <= `ICS_RST_SRC;
        end else begin
            pend <= next_pend;
        end
    end

    // Break and non-maskable requests wait for their own acceptance.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            brk_pend <= 1'b0;
            nmi_pend <= 1'b0;
        end else begin
            brk_pend <= software_break_instr || (brk_pend && !take_brk);
            nmi_pend <= nmi_req || (nmi_pend && !take_nmi);
        end
    end

    // Mask flag, break flag and the non-maskable block.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_i_flag <= 1'b0;
            psw_b_flag <= 1'b0;
            nmi_block <= 1'b0;
        end else begin
            if (take_mask || take_brk) begin
                irq_i_flag <= 1'b0; // RULE_03
            end else if (return_from_service_instr) begin
                irq_i_flag <= restore_psw[`ICS_PSW_I_BIT]; // RULE_08
            end else if (enable_irqs_instr) begin
                irq_i_flag <= 1'b1; // RULE_10
            end
            if (take_brk) begin
                psw_b_flag <= 1'b1; // RULE_13
            end else if (accept) begin
                psw_b_flag <= 1'b0;
            end else if (return_from_service_instr) begin
                psw_b_flag <= restore_psw[`ICS_PSW_B_BIT];
            end
            if (take_nmi) begin
                nmi_block <= 1'b1; // RULE_04
            end else if (return_from_service_instr) begin
                nmi_block <= 1'b0;
            end
        end
    end

    // Entry vector of the accepted source.
    always_comb begin
        next_vector = `ICS_VEC_LOWEST + {11'h000, acc_idx, 1'b0};
        if (kind == ICS_SRC_NMI) begin
            next_vector = NMI_VECTOR;
        end else if (kind == ICS_SRC_BREAK) begin
            next_vector = BRK_VECTOR; // RULE_13
        end
    end

    // Acceptance sequencer state and step counter.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ICS_IDLE;
            cnt <= 4'h0;
            kind <= ICS_SRC_MASKABLE;
            acc_idx <= 4'h0;
            saved_pc <= 16'h0000;
            saved_psw <= `ICS_RST_BYTE;
        end else begin
            case (state)
                ICS_IDLE: begin
                    cnt <= 4'h0;
                    if (accept) begin
                        state <= ICS_ACCEPT;
                        acc_idx <= win_idx;
                        kind <= take_nmi ? ICS_SRC_NMI : (take_brk ? ICS_SRC_BREAK : ICS_SRC_MASKABLE);
                        saved_pc <= ret_pc;
                        // Only the program counter and status word are captured.
                        saved_psw <= psw_in; // RULE_11
                        saved_psw[`ICS_PSW_I_BIT] <= irq_i_flag;
                        saved_psw[`ICS_PSW_B_BIT] <= take_brk;
                    end
                end
                ICS_ACCEPT: begin
                    cnt <= cnt + 4'h1;
                    if (cnt == `ICS_CNT_START) begin
                        state <= ICS_IDLE; // RULE_02
                    end
                end
                default: begin
                    state <= ICS_IDLE;
                end
            endcase
        end
    end

    // Stack pushes, vector load and routine start, all registered.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_busy <= 1'b0;
            stack_push <= 1'b0;
            stack_data <= `ICS_RST_BYTE;
            vector_addr <= 16'h0000;
            vector_load <= 1'b0;
            service_start <= 1'b0;
        end else begin
            seq_busy <= accept || (state == ICS_ACCEPT && cnt != `ICS_CNT_START);
            stack_push <= (state == ICS_ACCEPT) && cnt >= `ICS_CNT_PUSH_FIRST
                && cnt <= `ICS_CNT_PUSH_LAST; // RULE_06
            if (state == ICS_ACCEPT) begin
                if (cnt == 4'h0) begin
                    stack_data <= saved_pc[15:8];
                end else if (cnt == 4'h1) begin
                    stack_data <= saved_pc[7:0];
                end else if (cnt == `ICS_CNT_PUSH_LAST) begin
                    stack_data <= saved_psw;
                end
            end
            vector_load <= (state == ICS_ACCEPT) && cnt == `ICS_CNT_VEC_LOAD; // RULE_07
            if (state == ICS_ACCEPT && cnt == `ICS_CNT_VEC_LOAD) begin
                vector_addr <= next_vector;
            end
            service_start <= (state == ICS_ACCEPT) && cnt == `ICS_CNT_START;
        end
    end

    // Bus slave: zero wait states, always OKAY, write captured for the data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_valid <= 1'b0;
            wr_idx <= 10'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
        end else begin
            wr_valid <= hsel && htrans[1] && hwrite && hready;
            wr_idx <= haddr[11:2];
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hsel && htrans[1] && !hwrite && hready) begin
                hrdata <= next_rdata;
            end
        end
    end

    // Read decode; unmapped words read as zero.
    assign rd_idx = haddr[11:2];
    always_comb begin
        next_rdata = 32'h00000000;
        if (haddr[31:12] != 20'h00000) begin
            next_rdata = 32'h00000000;
        end else if (rd_idx == `ICS_IDX_EDGE_SEL) begin
            next_rdata[7:0] = ext_int_edge_select;
        end else if (rd_idx == `ICS_IDX_IEN_HIGH) begin
            next_rdata[7:0] = irq_enable_high;
        end else if (rd_idx == `ICS_IDX_IEN_LOW) begin
            next_rdata[7:0] = irq_enable_low;
        end else if (rd_idx == `ICS_IDX_PEND_HIGH) begin
            next_rdata[7:0] = pend[11:4];
        end else if (rd_idx == `ICS_IDX_PEND_LOW) begin
            next_rdata[7:4] = pend[3:0];
        end else if (rd_idx == `ICS_IDX_STATUS) begin
            next_rdata[4:0] = {psw_b_flag, nmi_block, irq_i_flag, brk_pend, seq_busy};
        end
    end

    // Writable configuration registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_int_edge_select <= `ICS_RST_BYTE;
            irq_enable_high <= `ICS_RST_BYTE;
            irq_enable_low <= `ICS_RST_BYTE;
        end else if (wr_valid) begin
            if (wr_idx == `ICS_IDX_EDGE_SEL) begin
                ext_int_edge_select <= hwdata[7:0];
            end else if (wr_idx == `ICS_IDX_IEN_HIGH) begin
                irq_enable_high <= hwdata[7:0];
            end else if (wr_idx == `ICS_IDX_IEN_LOW) begin
                irq_enable_low <= {hwdata[7:4], 4'h0};
            end
        end
    end

    sequence push_burst;
        stack_push [*3] ##1 !stack_push;
    endsequence

    chk_pend_held: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
        $fell(pend[11]) |-> $past(acc_clr[11] || (wr_valid && wr_idx == `ICS_IDX_PEND_HIGH)))
        else $error("Pending flag dropped without cause.");
    chk_accept_len: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
        accept |-> ##9 service_start)
        else $error("Acceptance did not take eight cycles.");
    chk_mask_clear: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_03
        take_mask |=> !irq_i_flag)
        else $error("Mask flag not cleared on acceptance.");
    chk_nmi_block: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_04
        take_nmi |=> nmi_block && !accept)
        else $error("Non-maskable acceptance did not block.");
    chk_src_clear: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_05
        take_mask |=> ((pend & $past(acc_clr) & ~$past(hw_set)) == 12'h000))
        else $error("Accepted source flag not cleared.");
    chk_three_push: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_06
        accept |-> ##2 push_burst)
        else $error("Expected exactly three pushes.");
    chk_vector_load: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_07
        accept |-> ##8 vector_load ##1 service_start)
        else $error("Vector load not before routine start.");
    chk_mask_gate: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_09
        accept && !irq_i_flag |-> take_nmi || take_brk)
        else $error("Maskable accepted while masked.");
    chk_ei_sets: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_10
        enable_irqs_instr && !accept && !return_from_service_instr |=> irq_i_flag)
        else $error("Enable instruction did not set mask flag.");
    chk_brk_lowest: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
        take_brk |-> !(irq_i_flag && win_found))
        else $error("Break taken over a higher source.");
    chk_set_wins: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_21
        |hw_set |=> ((pend & $past(hw_set)) == $past(hw_set)))
        else $error("Hardware set was lost.");
    chk_ext_latency: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_18
        $rose(pend[11]) |-> !service_start [*8])
        else $error("External response faster than allowed.");
endmodule

//--- verif/ics_core_model.sv
`timescale 1ns/1ps
module ics_core_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic [3:0] gap,
    input wire logic seq_busy,
    input wire logic stack_push,
    input wire logic [7:0] stack_data,
    input wire logic [15:0] vector_addr,
    input wire logic vector_load,
    input wire logic service_start,
    output logic instr_done,
    output logic [15:0] ret_pc,
    output logic [7:0] psw_in
);
    logic [3:0] cnt;
    logic [15:0] last_vec = 16'h0;
    logic [7:0] pb [0:2];
    int bc = 0;
    int pc = 0;
    int starts = 0;
    int last_busy = 0;
    int last_push = 0;
    // The core offers a fixed return address and status bits.
    assign ret_pc = 16'h1234;
    assign psw_in = 8'h01;
    // An instruction completes every gap plus one cycles while running; none completes during acceptance.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 4'h0;
            instr_done <= 1'b0;
        end else begin
            cnt <= (cnt >= gap) ? 4'h0 : cnt + 4'h1;
            instr_done <= run && !seq_busy && cnt == gap;
        end
    end
    // The stack side records pushed bytes, busy length, vector and routine starts.
    always @(posedge hclk) begin
        if (stack_push && pc < 3) begin
            pb[pc] <= stack_data;
        end
        pc <= seq_busy ? pc + int'(stack_push) : 0;
        bc <= seq_busy ? bc + 1 : 0;
        if (!seq_busy && bc != 0) begin
            last_busy <= bc;
            last_push <= pc;
        end
        if (vector_load) begin
            last_vec <= vector_addr;
        end
        if (service_start) begin
            starts <= starts + 1;
        end
    end
endmodule

//--- verif/tb_cpu_interrupt_sequencer.sv
`timescale 1ns/1ps
`include "ics_regs.svh"
module tb_cpu_interrupt_sequencer;
    import ics_pkg::*;
    localparam logic [9:0] EDG = `ICS_IDX_EDGE_SEL;
    localparam logic [9:0] ENH = `ICS_IDX_IEN_HIGH;
    localparam logic [9:0] ENL = `ICS_IDX_IEN_LOW;
    localparam logic [9:0] PDH = `ICS_IDX_PEND_HIGH;
    localparam logic [9:0] PDL = `ICS_IDX_PEND_LOW;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic run = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [3:0] pin = 4'h0;
    logic [3:0] ctl = 4'h0;
    logic [3:0] gap = 4'h3;
    logic [7:0] pset = 8'h00;
    logic [7:0] rpsw = 8'h04;
    logic [31:0] hrdata;
    logic hreadyout, hresp, idone, i_flag, b_flag, busy, push, vload, sstart;
    logic [7:0] program_status_word, sdata;
    logic [15:0] rpc, vaddr;
    logic [7:0] modes [0:4] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h01};
    logic [4:0] lvl = 5'b10101;
    logic [4:0] hit = 5'b01110;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    int t0 = 0;
    int t_end = 0;
    ics_sequencer dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .ext_irq_pin_a(pin[0]), .ext_irq_pin_b(pin[1]), .ext_irq_pin_c(pin[2]),
        .ext_irq_pin_d(pin[3]), .periph_irq_set(pset), .nmi_req(ctl[2]), .instr_done(idone),
        .enable_irqs_instr(ctl[0]), .software_break_instr(ctl[1]), .return_from_service_instr(ctl[3]),
        .restore_psw(rpsw), .psw_in(program_status_word), .ret_pc(rpc), .irq_i_flag(i_flag), .psw_b_flag(b_flag),
        .seq_busy(busy), .stack_push(push), .stack_data(sdata), .vector_addr(vaddr),
        .vector_load(vload), .service_start(sstart)
    );
    ics_core_model core (
        .hclk(hclk), .hresetn(hresetn), .run(run), .gap(gap), .seq_busy(busy), .stack_push(push),
        .stack_data(sdata), .vector_addr(vaddr), .vector_load(vload), .service_start(sstart),
        .instr_done(idone), .ret_pc(rpc), .psw_in(program_status_word)
    );
    always #5 hclk = ~hclk;
    // A hang is cut short long after the sequence should have ended.
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // One single AHB transfer; a set pulse may ride in the data phase.
    task automatic bus(input logic [9:0] i, input logic w, input logic [31:0] d, input logic [7:0] s);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {20'h0, i, 2'b00};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        pset <= s;
        @(posedge hclk);
        pset <= 8'h00;
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask
    task automatic wr(input logic [9:0] i, input logic [31:0] d);
        bus(i, 1'b1, d, 8'h00);
    endtask
    task automatic rd(input logic [9:0] i, input logic [31:0] e);
        bus(i, 1'b0, 32'h0, 8'h00);
        chk($sformatf("register %h", i), e, hrdata);
        chk("bus response", 32'h2, {30'h0, hreadyout, hresp});
    endtask
    // Pulses the core's instruction strobes or the non-maskable request for one cycle, then lets one edge pass.
    task automatic kick(input logic [3:0] m);
        ctl <= m;
        @(posedge hclk);
        ctl <= 4'h0;
        @(posedge hclk);
    endtask
    task automatic wait_start(input int n);
        for (int k = 0; k < 400 && core.starts < n; k++) @(posedge hclk);
        t_end = cyc;
        repeat (3) @(posedge hclk);
        chk("routine starts", n, core.starts);
    endtask
    // The main sequence works through acceptance, priority, masking and pins.
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(EDG, `ICS_RST_BYTE);
        rd(PDH, `ICS_RST_BYTE);
        chk("mask flag", 0, i_flag);
        wr(10'h000, 32'hff);
        rd(10'h000, 32'h0);
        wr(EDG, 32'hffff_ffa5);
        rd(EDG, 32'ha5);
        wr(ENH, 32'hff);
        wr(ENL, 32'hf0);
        wr(PDH, 32'h81);
        run <= 1'b1;
        repeat (40) @(posedge hclk);
        rd(PDH, 32'h81);
        chk("routine starts", 0, core.starts);
        bus(PDH, 1'b1, 32'h0, 8'h80);
        rd(PDH, 32'h20);
        run <= 1'b0;
        wr(PDH, 32'h24);
        kick(4'h1);
        chk("mask flag", 1, i_flag);
        run <= 1'b1;
        wait_start(1);
        chk("vector", 16'hfff6, core.last_vec);
        chk("mask flag", 0, i_flag);
        chk("busy cycles", `ICS_ACC_CYCLES, core.last_busy);
        chk("pushes", 3, core.last_push);
        chk("pc high", 8'h12, core.pb[0]);
        chk("pc low", 8'h34, core.pb[1]);
        rd(PDH, 32'h04);
        kick(4'h8);
        wait_start(2);
        chk("vector", 16'hfff0, core.last_vec);
        wr(ENL, 32'h00);
        wr(PDL, 32'h10);
        kick(4'h8);
        repeat (30) @(posedge hclk);
        rd(PDL, 32'h10);
        chk("routine starts", 2, core.starts);
        wr(ENL, 32'h10);
        wait_start(3);
        chk("vector", 16'hffe4, core.last_vec);
        run <= 1'b0;
        wr(ENL, 32'h80);
        wr(PDL, 32'h80);
        kick(4'h8);
        kick(4'h2);
        run <= 1'b1;
        wait_start(4);
        chk("vector", 16'hffea, core.last_vec);
        // The break ignores the mask flag, so it follows the converter's entry with no return.
        wait_start(5);
        chk("vector", 16'hffde, core.last_vec);
        chk("break flag", 1, b_flag);
        chk("pushed break bit", 1, core.pb[2][`ICS_PSW_B_BIT]);
        run <= 1'b0;
        kick(4'h4);
        run <= 1'b1;
        wait_start(6);
        chk("vector", 16'hfffc, core.last_vec);
        chk("break flag", 0, b_flag);
        rd(`ICS_IDX_STATUS, 32'h08);
        kick(4'h1);
        wr(PDL, 32'h80);
        repeat (30) @(posedge hclk);
        chk("routine starts", 6, core.starts);
        kick(4'h8);
        wait_start(7);
        run <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            wr(EDG, {24'h0, modes[i]});
            pin[0] <= lvl[i];
            repeat (8) @(posedge hclk);
            rd(PDH, hit[i] ? 32'h80 : 32'h00);
            wr(PDH, 32'h00);
        end
        wr(EDG, 32'h02);
        pin[0] <= 1'b0;
        repeat (8) @(posedge hclk);
        kick(4'h8);
        gap <= 4'h9;
        run <= 1'b1;
        pin[0] <= 1'b1;
        t0 = cyc;
        wait_start(8);
        chk("vector", 16'hfffa, core.last_vec);
        chk("response at least", 1, (t_end - t0) >= `ICS_MIN_RESPONSE);
        report_and_stop();
    end
endmodule
